// ---- rtl/dpcomm_map.svh ----
`ifndef DPCOMM_MAP_SVH
`define DPCOMM_MAP_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRL      14'h0000
`define IDX_HSHAKE    14'h0001
`define IDX_VARCNT    14'h0002
`define IDX_IRQ_STAT  14'h0003
`define IDX_IRQ_MASK  14'h0004
`define IDX_STATUS    14'h0005
`define IDX_LEVEL     14'h0788
`define IDX_VECTOR    14'h0789

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_TIRQ     0
`define CTRL_BIN      1
`define CTRL_TCOMM    2
`define CTRL_SERVO    3
`define CTRL_BGREP    4
`define CTRL_BGVAR    5
`define CTRL_LIM      8
`define VARCNT_WR     8
`define EV_LINE       0
`define EV_CTRLZ      1
`define EV_BIN        2
`define STAT_PEND     2

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RST_LEVEL     24'h000000
`define RST_VECTOR    24'h0000a1
`define LIMIT_MAX     4'h8
`define VAR_MAX       8'h80

`endif

// ---- rtl/dpcomm_pkg.sv ----
package dpcomm_pkg;

    typedef enum logic [1:0] {
        PORT_SERIAL = 2'b00,
        PORT_IO     = 2'b01,
        PORT_DPRAM  = 2'b10
    } resp_port_t;

    typedef enum logic [1:0] {
        VAR_CMP_FOUR  = 2'b00,
        VAR_CMP_ONE   = 2'b01,
        VAR_AUX_ZERO  = 2'b10,
        VAR_BACKPLANE = 2'b11
    } variant_t;

    typedef enum logic {
        WALK_IDLE = 1'b0,
        WALK_RUN  = 1'b1
    } walk_state_t;

    typedef struct packed {
        logic        text_irq_enable;
        logic        binary_buffer_enable;
        logic        text_comm_enable;
        logic        servo_report_enable;
        logic        background_report_enable;
        logic        background_var_buffer_enable;
        logic [3:0]  report_index_limit;
        logic [1:0]  handshake_mode_setting;
        logic [7:0]  var_rd_count;
        logic [7:0]  var_wr_count;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [23:0] level_setup;
        logic [23:0] vector_setup;
        resp_port_t  resp_port;
        logic        text_pending;
        logic        irq;
        logic        dpram_resp_write;
        logic        bin_accept;
        logic        iack_seen;
        logic [7:0]  vector_out;
        logic        cmp_four;
        logic        cmp_one;
        logic        aux_zero;
        logic        bus_req;
        logic [2:0]  bus_level;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } top_state_t;

endpackage

// ---- rtl/pin_sync.sv ----
module pin_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic d,
    output logic      q
);

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t s_q, s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;

endmodule

// ---- rtl/index_walker.sv ----
module index_walker
    import dpcomm_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Start and length
    input  wire logic         start,
    input  wire logic [W-1:0] count,
    // Walk output
    output logic              busy,
    output logic              strobe,
    output logic [W-1:0]      index
);

    typedef struct packed {
        walk_state_t  st;
        logic [W-1:0] idx;
        logic [W-1:0] lim;
        logic         stb;
    } walk_t;

    walk_t s_q, s_d;

    // A start while busy is dropped: a slow walk simply skips one cycle
    always_comb begin
        s_d     = s_q;
        s_d.stb = 1'b0;
        case (s_q.st)
            WALK_IDLE: begin
                if (start && count != '0) begin
                    s_d.st  = WALK_RUN;
                    s_d.idx = W'(1);
                    s_d.lim = count;
                    s_d.stb = 1'b1;
                end
            end
            WALK_RUN: begin
                if (s_q.idx == s_q.lim) begin
                    s_d.st = WALK_IDLE;
                end else begin
                    s_d.idx = s_q.idx + W'(1);
                    s_d.stb = 1'b1;
                end
            end
            default: s_d.st = WALK_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy   = (s_q.st == WALK_RUN);
    assign strobe = s_q.stb;
    assign index  = s_q.idx;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_walk_first: assert property (
        (s_q.st == WALK_IDLE && start && count != '0) |=> (strobe && index == W'(1)))
        else $error("walk did not begin at index one");
    a_walk_zero: assert property (
        (s_q.st == WALK_IDLE && start && count == '0) |=> !strobe)
        else $error("walk started with zero count");
    a_walk_bound: assert property (
        strobe |-> (index >= W'(1) && index <= s_q.lim))
        else $error("walk index outside limit");

endmodule

// ---- rtl/dpram_host_ctrl.sv ----
`include "dpcomm_map.svh"

module dpram_host_ctrl
    import dpcomm_pkg::*;
#(
    parameter variant_t VARIANT = VAR_CMP_ONE,
    parameter int       LIM_W   = 4,
    parameter int       VAR_W   = 8
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Firmware events, one-cycle pulses on pclk
    input  wire logic        cmd_io_seen,
    input  wire logic        cmd_dpram_seen,
    input  wire logic        ctrl_z_seen,
    input  wire logic        resp_line_valid,
    input  wire logic        host_bin_write,
    input  wire logic        servo_cycle,
    input  wire logic        bg_cycle,
    // Host acknowledge pin, asynchronous
    input  wire logic        host_irq_ack,
    // Firmware-facing results
    output logic      [1:0]  resp_port,
    output logic      [1:0]  handshake_mode,
    output logic             dpram_resp_write,
    output logic             bin_accept,
    output logic             servo_rpt_strobe,
    output logic [LIM_W-1:0] servo_rpt_index,
    output logic             bg_rpt_strobe,
    output logic [LIM_W-1:0] bg_rpt_index,
    output logic             var_rd_strobe,
    output logic [VAR_W-1:0] var_rd_index,
    output logic             var_wr_strobe,
    output logic [VAR_W-1:0] var_wr_index,
    // Host interrupt lines
    output logic             compare_output_four,
    output logic             compare_output_one,
    output logic             aux_control_line_zero,
    output logic             bus_irq_req,
    output logic      [2:0]  bus_irq_level,
    output logic      [7:0]  bus_irq_vector,
    output logic             irq
);

    top_state_t s_q, s_d;
    logic       iack_s;
    logic       setup_ph;
    logic       hit;
    logic       access_wr;
    logic       line_ok;
    logic       iack_rise;
    logic       servo_go;
    logic       bg_go;
    logic       var_go;
    logic [13:0] idx;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    pin_sync u_ack_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (host_irq_ack),
        .q     (iack_s)
    );

    assign idx       = paddr[15:2];
    assign setup_ph  = psel & ~penable;
    assign access_wr = psel & penable & s_q.pready & pwrite & hit;
    assign line_ok   = resp_line_valid & s_q.text_comm_enable
                       & (s_q.resp_port == PORT_DPRAM);
    assign iack_rise = iack_s & ~s_q.iack_seen;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0] lim;
        lim    = pwdata[`CTRL_LIM +: 4];
        s_d    = s_q;
        hit    = (paddr[1:0] == 2'b00);
        rd_val = '0;
        case (idx)
            `IDX_CTRL: begin
                rd_val[`CTRL_TIRQ]          = s_q.text_irq_enable;
                rd_val[`CTRL_BIN]           = s_q.binary_buffer_enable;
                rd_val[`CTRL_TCOMM]         = s_q.text_comm_enable;
                rd_val[`CTRL_SERVO]         = s_q.servo_report_enable;
                rd_val[`CTRL_BGREP]         = s_q.background_report_enable;
                rd_val[`CTRL_BGVAR]         = s_q.background_var_buffer_enable;
                rd_val[`CTRL_LIM +: 4]      = s_q.report_index_limit;
            end
            `IDX_HSHAKE:   rd_val[1:0] = s_q.handshake_mode_setting;
            `IDX_VARCNT: begin
                rd_val[7:0]                 = s_q.var_rd_count;
                rd_val[`VARCNT_WR +: 8]     = s_q.var_wr_count;
            end
            `IDX_IRQ_STAT: rd_val[2:0] = s_q.irq_status;
            `IDX_IRQ_MASK: rd_val[2:0] = s_q.irq_mask;
            `IDX_STATUS: begin
                rd_val[1:0]                 = s_q.resp_port;
                rd_val[`STAT_PEND]          = s_q.text_pending;
            end
            `IDX_LEVEL:    rd_val[23:0] = s_q.level_setup;
            `IDX_VECTOR:   rd_val[23:0] = s_q.vector_setup;
            default:       hit = 1'b0;
        endcase

        // Read data is caught in the setup cycle so that prdata is a flop
        s_d.pready  = setup_ph;
        s_d.pslverr = setup_ph & ~hit;
        if (setup_ph) begin
            s_d.prdata = rd_val;
        end

        if (access_wr) begin
            case (idx)
                `IDX_CTRL: begin
                    s_d.text_irq_enable              = pwdata[`CTRL_TIRQ];
                    s_d.binary_buffer_enable         = pwdata[`CTRL_BIN];
                    s_d.text_comm_enable             = pwdata[`CTRL_TCOMM];
                    s_d.servo_report_enable          = pwdata[`CTRL_SERVO];
                    s_d.background_report_enable     = pwdata[`CTRL_BGREP];
                    s_d.background_var_buffer_enable = pwdata[`CTRL_BGVAR];
                    s_d.report_index_limit = (lim > `LIMIT_MAX) ? `LIMIT_MAX : lim;
                    if (pwdata[`CTRL_TCOMM]) begin
                        s_d.handshake_mode_setting[0] = 1'b0;
                    end else if (s_q.resp_port == PORT_DPRAM) begin
                        s_d.resp_port = PORT_SERIAL;
                    end
                end
                `IDX_HSHAKE: s_d.handshake_mode_setting = pwdata[1:0];
                `IDX_VARCNT: begin
                    s_d.var_rd_count = (pwdata[7:0] > `VAR_MAX) ? `VAR_MAX : pwdata[7:0];
                    s_d.var_wr_count = (pwdata[`VARCNT_WR +: 8] > `VAR_MAX)
                                       ? `VAR_MAX : pwdata[`VARCNT_WR +: 8];
                end
                `IDX_IRQ_STAT: s_d.irq_status   = s_q.irq_status & ~pwdata[2:0];
                `IDX_IRQ_MASK: s_d.irq_mask     = pwdata[2:0];
                `IDX_LEVEL:    s_d.level_setup  = pwdata[23:0];
                `IDX_VECTOR:   s_d.vector_setup = pwdata[23:0];
                default: ;
            endcase
        end

        // Port follows the latest command; DPRAM commands need text comm
        if (cmd_io_seen) begin
            s_d.resp_port = PORT_IO;
        end
        if (cmd_dpram_seen && s_q.text_comm_enable) begin
            s_d.resp_port = PORT_DPRAM;
        end
        // Control-Z is the newest event, so it overrides a same-cycle write
        if (ctrl_z_seen) begin
            s_d.text_comm_enable = 1'b0;
            s_d.resp_port        = PORT_SERIAL;
        end

        s_d.dpram_resp_write = line_ok;
        s_d.bin_accept       = host_bin_write & s_q.binary_buffer_enable;

        // Host acknowledge clears the pending line; a new line wins
        s_d.iack_seen = iack_s;
        if (iack_rise) begin
            s_d.text_pending = 1'b0;
        end
        if (line_ok && s_q.text_irq_enable) begin
            s_d.text_pending = 1'b1;
        end

        s_d.irq_status[`EV_LINE]  = s_d.irq_status[`EV_LINE] | line_ok;
        s_d.irq_status[`EV_CTRLZ] = s_d.irq_status[`EV_CTRLZ] | ctrl_z_seen;
        s_d.irq_status[`EV_BIN]   = s_d.irq_status[`EV_BIN] | s_d.bin_accept;
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);

        // Only the line of the chosen build is ever driven
        s_d.cmp_four  = s_d.text_pending & (VARIANT == VAR_CMP_FOUR);
        s_d.cmp_one   = s_d.text_pending & (VARIANT == VAR_CMP_ONE);
        s_d.aux_zero  = s_d.text_pending & (VARIANT == VAR_AUX_ZERO);
        s_d.bus_req   = s_d.text_pending & (VARIANT == VAR_BACKPLANE);
        s_d.bus_level = (VARIANT == VAR_BACKPLANE) ? s_d.level_setup[2:0] : 3'h0;
        s_d.vector_out = (iack_s && VARIANT == VAR_BACKPLANE)
                         ? s_q.vector_setup[7:0] + 8'h01 : 8'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q              <= '0;
            s_q.level_setup  <= `RST_LEVEL;
            s_q.vector_setup <= `RST_VECTOR;
            s_q.resp_port    <= PORT_SERIAL;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Report and variable walkers
    // ----------------------------------------------------------------
    // Limit zero gives a zero count, so the walker stays idle
    assign servo_go = servo_cycle & s_q.servo_report_enable;
    assign bg_go    = bg_cycle & s_q.background_report_enable;
    assign var_go   = bg_cycle & s_q.background_var_buffer_enable;

    index_walker #(.W(LIM_W)) u_servo (
        .clk    (pclk),
        .rst_n  (presetn),
        .start  (servo_go),
        .count  (s_q.report_index_limit),
        .busy   (),
        .strobe (servo_rpt_strobe),
        .index  (servo_rpt_index)
    );

    index_walker #(.W(LIM_W)) u_bg (
        .clk    (pclk),
        .rst_n  (presetn),
        .start  (bg_go),
        .count  (s_q.report_index_limit),
        .busy   (),
        .strobe (bg_rpt_strobe),
        .index  (bg_rpt_index)
    );

    index_walker #(.W(VAR_W)) u_var_rd (
        .clk    (pclk),
        .rst_n  (presetn),
        .start  (var_go),
        .count  (s_q.var_rd_count),
        .busy   (),
        .strobe (var_rd_strobe),
        .index  (var_rd_index)
    );

    index_walker #(.W(VAR_W)) u_var_wr (
        .clk    (pclk),
        .rst_n  (presetn),
        .start  (var_go),
        .count  (s_q.var_wr_count),
        .busy   (),
        .strobe (var_wr_strobe),
        .index  (var_wr_index)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata                = s_q.prdata;
    assign pready                = s_q.pready;
    assign pslverr               = s_q.pslverr;
    assign resp_port             = s_q.resp_port;
    assign handshake_mode        = s_q.handshake_mode_setting;
    assign dpram_resp_write      = s_q.dpram_resp_write;
    assign bin_accept            = s_q.bin_accept;
    assign compare_output_four   = s_q.cmp_four;
    assign compare_output_one    = s_q.cmp_one;
    assign aux_control_line_zero = s_q.aux_zero;
    assign bus_irq_req           = s_q.bus_req;
    assign bus_irq_level         = s_q.bus_level;
    assign bus_irq_vector        = s_q.vector_out;
    assign irq                   = s_q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_line_irq_on: assert property (
        (line_ok && s_q.text_irq_enable && !iack_s)
        |=> (compare_output_four | compare_output_one | aux_control_line_zero | bus_irq_req))
        else $error("line loaded without host interrupt");
    a_line_irq_off: assert property (
        $rose(s_q.text_pending) |-> $past(s_q.text_irq_enable && line_ok))
        else $error("interrupt raised while disabled");
    a_cmp_dedicated: assert property (
        (compare_output_four | compare_output_one) |-> (s_q.text_pending && !bus_irq_req))
        else $error("compare line used for another purpose");
    a_aux_dedicated: assert property (
        aux_control_line_zero |-> (VARIANT == VAR_AUX_ZERO && s_q.text_pending))
        else $error("auxiliary line driven wrongly");
    a_bus_level: assert property (
        bus_irq_req |-> (bus_irq_level == s_q.level_setup[2:0]))
        else $error("interrupt on wrong bus level");
    a_vector_plus: assert property (
        (iack_s && VARIANT == VAR_BACKPLANE)
        |=> (bus_irq_vector == $past(s_q.vector_setup[7:0]) + 8'h01))
        else $error("acknowledge vector not setup plus one");
    a_bin_gate: assert property (
        bin_accept |-> $past(host_bin_write && s_q.binary_buffer_enable))
        else $error("binary write accepted while disabled");
    a_port_follow: assert property (
        (cmd_io_seen && !cmd_dpram_seen && !ctrl_z_seen) |=> (resp_port == PORT_IO))
        else $error("response port did not follow command");
    a_ctrl_z: assert property (
        ctrl_z_seen |=> (!s_q.text_comm_enable && resp_port == PORT_SERIAL))
        else $error("control-z did not restore serial port");
    a_hshake_force: assert property (
        (access_wr && idx == `IDX_CTRL && pwdata[`CTRL_TCOMM])
        |=> (handshake_mode == {$past(handshake_mode[1]), 1'b0}))
        else $error("handshake mode not forced");
    a_limit_zero: assert property (
        (s_q.report_index_limit == 4'h0 && !servo_rpt_strobe) |=> !servo_rpt_strobe)
        else $error("report issued with zero limit");
    a_bg_limit_zero: assert property (
        (s_q.report_index_limit == 4'h0 && !bg_rpt_strobe) |=> !bg_rpt_strobe)
        else $error("background report issued with zero limit");
    a_var_bound: assert property (
        (var_rd_strobe || var_wr_strobe)
        |-> (var_rd_index <= `VAR_MAX && var_wr_index <= `VAR_MAX))
        else $error("variable buffer index above limit");

    c_line_irq:  cover property (line_ok && s_q.text_irq_enable);
    c_ctrl_z:    cover property (ctrl_z_seen && s_q.text_comm_enable);
    c_full_walk: cover property (servo_rpt_strobe && servo_rpt_index == `LIMIT_MAX);
    c_iack:      cover property (iack_rise && s_q.text_pending);

endmodule

// ---- verification/host_model.sv ----
module host_model (
    // Clock and answer
    input  wire logic        pclk,
    input  wire logic        pready,
    // Request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [15:0]      paddr,
    output logic [31:0]      pwdata,
    // Acknowledge pin
    output logic             host_irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    int n_to = 0;

    initial begin
        {psel, penable, pwrite, paddr, pwdata, host_irq_ack} = '0;
    end

    // ------------------------------------------------------------
    // Transfer: held until pready is seen high at a rising edge, or 40 edges pass
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Read at the edge itself: the slave's flops update only after it
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) n_to++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Acknowledge pin moves just after a rising edge, like the bus lines
    task automatic ack(input logic v);
        @(posedge pclk);
        host_irq_ack <= v;
    endtask
endmodule

// ---- verification/dpram_host_ctrl_tb.sv ----
module dpram_host_ctrl_tb
    import dpcomm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [6:0]  ev = '0;
    logic        psel, penable, pwrite, pready, pslverr, host_irq_ack;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  resp_port, hs_mode;
    logic        dpram_resp_write, bin_accept, servo_rpt_strobe, bg_rpt_strobe;
    logic        var_rd_strobe, var_wr_strobe;
    logic [3:0]  servo_rpt_index, bg_rpt_index, lim;
    logic        cmp_one, bus_irq_req, irq;
    logic [2:0]  bus_irq_level;
    logic [7:0]  bus_irq_vector;
    logic [32:0] exp_q[$];
    logic [32:0] e_rd;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cnt;
    int          cnt2;
    logic [3:0]  last;

    initial forever #20 pclk = ~pclk;

    host_model host_u (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .host_irq_ack(host_irq_ack));

    dpram_host_ctrl #(.VARIANT(VAR_BACKPLANE)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_io_seen(ev[0]),
        .cmd_dpram_seen(ev[1]), .ctrl_z_seen(ev[2]), .resp_line_valid(ev[3]),
        .host_bin_write(ev[4]), .servo_cycle(ev[5]), .bg_cycle(ev[6]),
        .host_irq_ack(host_irq_ack), .resp_port(resp_port), .handshake_mode(hs_mode),
        .dpram_resp_write(dpram_resp_write), .bin_accept(bin_accept),
        .servo_rpt_strobe(servo_rpt_strobe), .servo_rpt_index(servo_rpt_index),
        .bg_rpt_strobe(bg_rpt_strobe), .bg_rpt_index(bg_rpt_index),
        .var_rd_strobe(var_rd_strobe), .var_rd_index(), .var_wr_strobe(var_wr_strobe),
        .var_wr_index(), .compare_output_four(),
        .compare_output_one(cmp_one), .aux_control_line_zero(), .bus_irq_req(bus_irq_req),
        .bus_irq_level(bus_irq_level), .bus_irq_vector(bus_irq_vector), .irq(irq));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Read data is matched against the oldest note at the edge it is taken
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            e_rd = exp_q.pop_front();
            chk("prdata", prdata, e_rd[31:0]);
            chk("pslverr", 32'(pslverr), 32'(e_rd[32]));
        end
    end

    // Bit 32 of the note is the expected error flag
    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        host_u.xfer(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d);
    endtask

    // One-cycle firmware event; returns once its effect has settled
    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev    <= '0;
        #1;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic wrap_up;
        n_fail += host_u.n_to;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(87740));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(16'h0000, 32'h0);
        rd(16'h1e24, 32'h0000_00a1);
        rd(16'h0040, 33'h1_0000_0000);
        wr(16'h1e20, 32'h5);
        cyc(2);
        chk("bus_irq_level", 32'(bus_irq_level), 32'h5);
        wr(16'h0004, 32'h3);
        wr(16'h0000, 32'h5);
        rd(16'h0004, 32'h2);
        chk("handshake_mode", 32'(hs_mode), 32'h2);
        wr(16'h0004, 32'h1);
        wr(16'h0000, 32'h5);
        rd(16'h0004, 32'h0);
        pulse(1);
        chk("resp_port", 32'(resp_port), 32'h2);
        pulse(3);
        chk("dpram_resp_write", 32'(dpram_resp_write), 32'h1);
        chk("bus_irq_req", 32'(bus_irq_req), 32'h1);
        chk("cmp_one", 32'(cmp_one), 32'h0);
        wr(16'h0010, 32'h1);
        cyc(2);
        chk("irq", 32'(irq), 32'h1);
        wr(16'h000c, 32'h1);
        cyc(2);
        chk("irq", 32'(irq), 32'h0);
        host_u.ack(1'b1);
        cyc(6);
        chk("bus_irq_vector", 32'(bus_irq_vector), 32'ha2);
        chk("bus_irq_req", 32'(bus_irq_req), 32'h0);
        host_u.ack(1'b0);
        pulse(0);
        chk("resp_port", 32'(resp_port), 32'h1);
        pulse(3);
        chk("dpram_resp_write", 32'(dpram_resp_write), 32'h0);
        pulse(2);
        chk("resp_port", 32'(resp_port), 32'h0);
        rd(16'h0000, 32'h1);
        wr(16'h0000, 32'h4);
        pulse(1);
        pulse(3);
        cyc(2);
        chk("bus_irq_req", 32'(bus_irq_req), 32'h0);
        pulse(4);
        chk("bin_accept", 32'(bin_accept), 32'h0);
        wr(16'h0000, 32'h2);
        pulse(4);
        chk("bin_accept", 32'(bin_accept), 32'h1);
        // Random limit on both walkers, then limit zero
        for (int k = 0; k < 4; k++) begin
            lim = (k < 2) ? 4'($urandom_range(8, 1)) : 4'h0;
            wr(16'h0000, {20'h0, lim, 8'h18});
            pulse(5 + k % 2);
            cnt = 0;
            last = '0;
            repeat (12) begin
                if ((k % 2 ? bg_rpt_strobe : servo_rpt_strobe) === 1'b1) begin
                    cnt++;
                    last = k % 2 ? bg_rpt_index : servo_rpt_index;
                end
                cyc(1);
            end
            chk("strobe_count", 32'(cnt), 32'(lim));
            chk("last_index", 32'(last), 32'(lim));
        end
        // Variable buffers: the write count saturates at 128
        wr(16'h0008, 32'h0000_9003);
        rd(16'h0008, 32'h0000_8003);
        wr(16'h0000, 32'h0000_0020);
        pulse(6);
        cnt = 0;
        cnt2 = 0;
        repeat (140) begin
            if (var_rd_strobe === 1'b1) cnt++;
            if (var_wr_strobe === 1'b1) cnt2++;
            cyc(1);
        end
        chk("var_rd_count", 32'(cnt), 32'h3);
        chk("var_wr_count", 32'(cnt2), 32'h80);
        wrap_up();
    end
endmodule
